// file: shared/trace_cfg_pkg.sv
/*
  Package for the trace output configuration block: register byte offsets,
  field positions, reset values, protocol codes and the control word carried
  to the output datapath.
  Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package trace_cfg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] SUPPORTED_PORT_WIDTHS_OFS   = 12'h000;
  localparam logic [11:0] CURRENT_PORT_WIDTH_OFS      = 12'h004;
  localparam logic [11:0] ASYNC_BAUD_DIVIDER_OFS      = 12'h010;
  localparam logic [11:0] PIN_PROTOCOL_SELECT_OFS     = 12'h0f0;
  localparam logic [11:0] FORMATTER_FLUSH_STATUS_OFS  = 12'h300;
  localparam logic [11:0] FORMATTER_FLUSH_CONTROL_OFS = 12'h304;
  localparam logic [11:0] SYNC_PERIOD_CONTROL_OFS     = 12'h308;
  localparam logic [11:0] TRIGGER_INPUT_STATE_OFS     = 12'hee8;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int WIDTH_FIELD_BITS   = 4;
  localparam int PROTOCOL_BITS      = 2;
  localparam int SYNC_COUNT_BITS    = 5;
  localparam int PRESCALER_BITS     = 13;
  localparam int SYNC_CNT_BITS      = 17;
  localparam int STAT_UNSTOPPABLE   = 3;
  localparam int STAT_CAPTURE       = 2;
  localparam int STAT_HALTED        = 1;
  localparam int STAT_FLUSH_PENDING = 0;
  localparam int CTRL_TRIGGER_INS   = 8;
  localparam int CTRL_MANUAL_FLUSH  = 6;
  localparam int CTRL_CONT_FORMAT   = 1;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  WIDTH_1BIT       = 4'h1;
  localparam logic [3:0]  WIDTH_2BIT       = 4'h2;
  localparam logic [3:0]  WIDTH_4BIT       = 4'h8;
  localparam logic [3:0]  SUPPORT_MAX1     = 4'h1;
  localparam logic [3:0]  SUPPORT_MAX2     = 4'h3;
  localparam logic [3:0]  SUPPORT_MAX4     = 4'hb;
  localparam logic [1:0]  PROTO_PARALLEL   = 2'h0;
  localparam logic [1:0]  PROTO_MANCHESTER = 2'h1;
  localparam logic [1:0]  PROTO_NRZ        = 2'h2;
  localparam logic [1:0]  PROTOCOL_RESET   = 2'h1;
  localparam logic [4:0]  SYNC_COUNT_MIN   = 5'h07;
  localparam logic [4:0]  SYNC_COUNT_MAX   = 5'h10;
  localparam logic        CONT_FMT_RESET   = 1'b1;
  localparam logic [12:0] PRESCALER_RESET  = 13'h0000;

  // control word handed to the output datapath
  typedef struct packed {
    logic [2:0] portWidthCode;   // 0: 1 bit, 1: 2 bits, 3: 4 bits
    logic [1:0] protocol;
    logic       formatterOn;
    logic       bypassSecond;    // discard second trace input
  } out_cfg_t;

  typedef enum logic [2:0] {
    FL_IDLE  = 3'b001,
    FL_SYNC  = 3'b010,
    FL_DRAIN = 3'b100
  } flush_state_t;

endpackage

// file: hdl/trace_output_config.sv
/*
  Configuration and status logic of the trace output unit: port width,
  pin protocol, periodic sync interval, async baud divider, formatter flush
  control and trigger readback, reached over Avalon-MM with waitrequest.
  Assumes the output datapath reports when it has drained a flush and when
  a sync packet has been emitted; trigger pin is asynchronous.
*/
// Notes on behaviour
// - supported-width register: bit n set means port width n+1 supported
// - supported widths follow max-width tie: 0b0011 for 2 bits, 0b1011 for 4
// - current width one-hot: 0b0001 1 bit, 0b0010 2 bits, 0b1000 4 bits
// - several bits set in current width: highest set bit decides
// - protocol field: 0 parallel, 1 Manchester single pin, 2 NRZ single pin
// - sync reload is two to the sync count, in bytes, ceiling 2^16
// - sync count below 0b00111 disables periodic sync counter
// - sync count above 0b10000 reloads the maximum interval
// - async bit rate is source clock over prescaler plus one
// - status bit 3 reads one: formatter cannot be stopped
// - status bits 2 and 1 always read zero
// - flush pending sets at flush start, clears when prior data left
// - control bit 8 always reads one: triggers inserted
// - writing one to control bit 6 flushes; bit clears on completion
// - control bit 1 enables continuous formatting
// - parallel protocol forces formatter on; single pin restores setting
// - trigger register bit 0 reads trigger input level, others zero
// - bypassed single-pin mode passes first input only, drops second
// - sync request completes partial frame then emits a sync packet
module trace_output_config
  import trace_cfg_pkg::*;
#(
  parameter logic [3:0] MAX_PORT_WIDTH_TIE = SUPPORT_MAX4
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             response,
  input  wire logic        triggerPin,
  input  wire logic        flushDrained,
  input  wire logic        syncSent,
  input  wire logic [7:0]  bytesSent,
  output out_cfg_t         outCfg,
  output logic             flushRequest,
  output logic             syncRequest,
  output logic             baudTick
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // highest set bit of the width field gives the active width
  function automatic logic [2:0] width_code(input logic [3:0] w);
    if (w[3]) width_code = 3'h3;
    else if (w[2]) width_code = 3'h2;
    else if (w[1]) width_code = 3'h1;
    else width_code = 3'h0;
  endfunction

  // merge write data into a field under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]            currentWidth;
  logic [1:0]            protocolSel;
  logic [4:0]            syncCount;
  logic [12:0]           prescaler;
  logic                  contFormatCfg;
  logic                  manualFlush;
  logic                  flushPending;
  flush_state_t          flushState;
  logic                  trigMeta;
  logic                  trigSync;
  logic                  answered;
  logic [SYNC_CNT_BITS-1:0] syncCounter;
  logic [PRESCALER_BITS-1:0] baudCounter;
  logic                  access;
  logic                  wrHit;
  logic [31:0]           next_readdata;
  logic                  next_response;
  logic                  contFormatEff;
  logic [SYNC_CNT_BITS-1:0] syncReload;

  assign access = (read | write) & ~answered;
  assign wrHit  = write & ~answered;

  // parallel port forces the formatter on, stored setting is kept
  assign contFormatEff = (protocolSel == PROTO_PARALLEL) ? 1'b1 : contFormatCfg;

  // reload value: 2^n bytes, clamped to 2^16
  always_comb begin
    if (syncCount > SYNC_COUNT_MAX) begin
      syncReload = SYNC_CNT_BITS'(1) << SYNC_COUNT_MAX;
    end else begin
      syncReload = SYNC_CNT_BITS'(1) << syncCount;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, answer on the second
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      answered    <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      answered    <= access;
      waitrequest <= ~access;
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    next_response = 1'b0;
    case (address)
      SUPPORTED_PORT_WIDTHS_OFS: next_readdata[3:0] = MAX_PORT_WIDTH_TIE;
      CURRENT_PORT_WIDTH_OFS:    next_readdata[3:0] = currentWidth;
      ASYNC_BAUD_DIVIDER_OFS:    next_readdata[12:0] = prescaler;
      PIN_PROTOCOL_SELECT_OFS:   next_readdata[1:0] = protocolSel;
      FORMATTER_FLUSH_STATUS_OFS: begin
        next_readdata[STAT_UNSTOPPABLE]   = 1'b1;
        next_readdata[STAT_CAPTURE]       = 1'b0;
        next_readdata[STAT_HALTED]        = 1'b0;
        next_readdata[STAT_FLUSH_PENDING] = flushPending;
      end
      FORMATTER_FLUSH_CONTROL_OFS: begin
        next_readdata[CTRL_TRIGGER_INS]  = 1'b1;
        next_readdata[CTRL_MANUAL_FLUSH] = manualFlush;
        next_readdata[CTRL_CONT_FORMAT]  = contFormatEff;
      end
      SYNC_PERIOD_CONTROL_OFS:   next_readdata[4:0] = syncCount;
      TRIGGER_INPUT_STATE_OFS:   next_readdata[0] = trigSync;
      default:                   next_response = 1'b1; // unmapped: slave error
    endcase
  end

  // read data and response register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
      response <= 1'b0;
    end else if (access) begin
      readdata <= read ? next_readdata : 32'h0000_0000;
      response <= next_response;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      currentWidth  <= WIDTH_1BIT;
      protocolSel   <= PROTOCOL_RESET;
      syncCount     <= 5'h00;
      prescaler     <= PRESCALER_RESET;
      contFormatCfg <= CONT_FMT_RESET;
    end else if (wrHit) begin
      case (address)
        CURRENT_PORT_WIDTH_OFS:  currentWidth <= 4'(be_merge(32'(currentWidth), writedata,
                                                             byteenable));
        PIN_PROTOCOL_SELECT_OFS: if (byteenable[0]) protocolSel <= writedata[1:0];
        SYNC_PERIOD_CONTROL_OFS: if (byteenable[0]) syncCount <= writedata[4:0];
        ASYNC_BAUD_DIVIDER_OFS:  prescaler <= 13'(be_merge(32'(prescaler), writedata,
                                                           byteenable));
        FORMATTER_FLUSH_CONTROL_OFS: if (byteenable[0]) begin
          contFormatCfg <= writedata[CTRL_CONT_FORMAT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flush sequencing: idle straight to drain, FL_SYNC never entered
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flushState   <= FL_IDLE;
      manualFlush  <= 1'b0;
      flushPending <= 1'b0;
      flushRequest <= 1'b0;
    end else begin
      case (flushState)
        FL_IDLE: if (wrHit && address == FORMATTER_FLUSH_CONTROL_OFS && byteenable[0]
                     && writedata[CTRL_MANUAL_FLUSH]) begin
          manualFlush  <= 1'b1;
          flushPending <= 1'b1;
          flushRequest <= 1'b1;
          flushState   <= FL_DRAIN;
        end
        FL_DRAIN: begin
          flushRequest <= 1'b0;
          if (flushDrained) begin
            manualFlush  <= 1'b0;
            flushPending <= 1'b0;
            flushState   <= FL_IDLE;
          end
        end
        default: flushState <= FL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trigger pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
    end else begin
      trigMeta <= triggerPin;
      trigSync <= trigMeta;
    end
  end

  // ----------------------------------------------------------------
  // periodic sync counter in bytes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      syncCounter <= '0;
      syncRequest <= 1'b0;
    end else if (syncCount < SYNC_COUNT_MIN) begin
      syncCounter <= '0;
      syncRequest <= 1'b0;
    end else if (syncRequest) begin
      // hold until the formatter closes the frame and sends sync
      if (syncSent) begin
        syncRequest <= 1'b0;
        syncCounter <= '0;
      end
    end else if (SYNC_CNT_BITS'(syncCounter + SYNC_CNT_BITS'(bytesSent)) >= syncReload) begin
      syncRequest <= 1'b1;
    end else begin
      syncCounter <= SYNC_CNT_BITS'(syncCounter + SYNC_CNT_BITS'(bytesSent));
    end
  end

  // ----------------------------------------------------------------
  // baud divider: one tick every prescaler+1 cycles
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      baudCounter <= '0;
      baudTick    <= 1'b0;
    end else if (baudCounter >= prescaler) begin
      baudCounter <= '0;
      baudTick    <= 1'b1;
    end else begin
      baudCounter <= baudCounter + 13'h0001;
      baudTick    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control word to datapath
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      outCfg <= '{portWidthCode: 3'h0, protocol: PROTOCOL_RESET, formatterOn: CONT_FMT_RESET,
                  bypassSecond: 1'b0};
    end else begin
      outCfg.portWidthCode <= width_code(currentWidth);
      outCfg.protocol      <= protocolSel;
      outCfg.formatterOn   <= contFormatEff;
      outCfg.bypassSecond  <= (protocolSel != PROTO_PARALLEL) & ~contFormatCfg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_answer_after_one;
    @(posedge ref_clk) disable iff (!rstn)
      ((read | write) && waitrequest && !answered) |=> !waitrequest;
  endproperty
  a_answer_after_one: assert property (p_answer_after_one) else $error("no answer");

  property p_flush_set;
    @(posedge ref_clk) disable iff (!rstn)
      (flushState == FL_IDLE && wrHit && address == FORMATTER_FLUSH_CONTROL_OFS
       && byteenable[0] && writedata[CTRL_MANUAL_FLUSH]) |=> (manualFlush && flushPending);
  endproperty
  a_flush_set: assert property (p_flush_set) else $error("flush not started");

  property p_flush_clear;
    @(posedge ref_clk) disable iff (!rstn)
      (flushState == FL_DRAIN && flushDrained) |=> (!manualFlush && !flushPending);
  endproperty
  a_flush_clear: assert property (p_flush_clear) else $error("flush not cleared");

  property p_parallel_forces;
    @(posedge ref_clk) disable iff (!rstn)
      (protocolSel == PROTO_PARALLEL) |=> outCfg.formatterOn;
  endproperty
  a_parallel_forces: assert property (p_parallel_forces) else $error("formatter off");

  property p_sync_disabled;
    @(posedge ref_clk) disable iff (!rstn)
      (syncCount < SYNC_COUNT_MIN) |=> !syncRequest;
  endproperty
  a_sync_disabled: assert property (p_sync_disabled) else $error("sync while off");

  property p_baud_period;
    @(posedge ref_clk) disable iff (!rstn)
      ($rose(baudTick) && prescaler == 13'h0001 && $stable(prescaler)) |=> !baudTick ##1 baudTick;
  endproperty
  a_baud_period: assert property (p_baud_period) else $error("baud period");

  property p_width_msb;
    @(posedge ref_clk) disable iff (!rstn)
      (currentWidth[3] && $stable(currentWidth)) |=> (outCfg.portWidthCode == 3'h3);
  endproperty
  a_width_msb: assert property (p_width_msb) else $error("width not msb");

  property p_trigger_level;
    @(posedge ref_clk) disable iff (!rstn)
      (triggerPin) ##1 (triggerPin) |=> trigSync;
  endproperty
  a_trigger_level: assert property (p_trigger_level) else $error("trigger lag");

  // request edge: slave has not answered yet
  sequence s_taken;
    (read | write) && waitrequest && !answered;
  endsequence

  // answer edge: request still held, waitrequest low
  sequence s_answer;
    (read | write) && !waitrequest;
  endsequence

  // flush start strobe
  sequence s_flush_launch;
    flushRequest;
  endsequence

  property p_one_answer;
    @(posedge ref_clk) disable iff (!rstn)
      s_taken ##1 s_answer |=> waitrequest;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("answer held");

  property p_status_fixed;
    @(posedge ref_clk) disable iff (!rstn)
      s_answer ##0 (read && address == FORMATTER_FLUSH_STATUS_OFS)
        |-> (readdata[31:1] == 31'h0000_0004);
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status bits");

  property p_control_fixed;
    @(posedge ref_clk) disable iff (!rstn)
      s_answer ##0 (read && address == FORMATTER_FLUSH_CONTROL_OFS)
        |-> (readdata[31:7] == 25'h000_0002 && readdata[5:2] == 4'h0 && !readdata[0]);
  endproperty
  a_control_fixed: assert property (p_control_fixed) else $error("control bits");

  property p_flush_pulse;
    @(posedge ref_clk) disable iff (!rstn)
      s_flush_launch |=> !flushRequest;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush strobe long");

  property p_bypass;
    @(posedge ref_clk) disable iff (!rstn)
      (protocolSel != PROTO_PARALLEL && !contFormatCfg) |=> outCfg.bypassSecond;
  endproperty
  a_bypass: assert property (p_bypass) else $error("no bypass");

  property p_sync_release;
    @(posedge ref_clk) disable iff (!rstn)
      (syncRequest && syncSent) |=> !syncRequest;
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("sync held");

endmodule

// file: test/trace_capture_model.sv
/*
  Model of the trace datapath and capture analyzer beyond the config block.
  Assumes flush requests are one-cycle pulses and sync requests are levels.
*/
module trace_capture_model #(
  parameter int DRAIN = 12,
  parameter int LAG   = 3
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       flushRequest,
  input  wire logic       syncRequest,
  input  wire logic [7:0] rate,
  output logic            flushDrained,
  output logic            syncSent,
  output logic [7:0]      bytesSent,
  output logic [7:0]      flushCount
);
  timeunit 1ns;
  timeprecision 1ps;
  int   drainLeft;
  int   syncLeft;
  logic armed;

  // drain data queued before the flush, then report it has left
  always @(posedge ref_clk) begin
    if (!rstn) begin
      drainLeft    <= 0;
      flushCount   <= 8'h00;
      flushDrained <= 1'b0;
    end else if (flushRequest) begin
      drainLeft    <= DRAIN;
      flushCount   <= flushCount + 8'h01;
      flushDrained <= 1'b0;
    end else begin
      if (drainLeft > 0) drainLeft <= drainLeft - 1;
      flushDrained <= (drainLeft == 1);
    end
  end

  // close the frame and send a sync packet a few cycles after a request
  always @(posedge ref_clk) begin
    bytesSent <= rstn ? rate : 8'h00;
    if (!rstn || !syncRequest) begin
      armed    <= 1'b1;
      syncLeft <= 0;
      syncSent <= 1'b0;
    end else if (armed) begin
      armed    <= 1'b0;
      syncLeft <= LAG;
      syncSent <= 1'b0;
    end else begin
      if (syncLeft > 0) syncLeft <= syncLeft - 1;
      syncSent <= (syncLeft == 1);
    end
  end
endmodule

// file: test/trace_output_config_tb.sv
/*
  Self-checking bench for the trace output configuration block.
  Assumes the capture model answers flush and sync requests.
*/
module trace_output_config_tb
  import trace_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and hookup
  // ----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] address = 12'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        response;
  logic        triggerPin = 1'b0;
  logic        flushDrained;
  logic        syncSent;
  logic [7:0]  bytesSent;
  logic [7:0]  rate = 8'h01;
  logic [7:0]  flushCount;
  out_cfg_t    outCfg;
  logic        flushRequest;
  logic        syncRequest;
  logic        baudTick;
  logic [31:0] rdData;
  logic        rdResp;
  int          n_errors = 0;
  int          compares = 0;
  logic [3:0]  widthVal [5] = '{4'h1, 4'h2, 4'h8, 4'hb, 4'h3};
  logic [2:0]  widthCode [5] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h1};

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  trace_output_config u_trace_output_config (
    .ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .triggerPin(triggerPin),
    .flushDrained(flushDrained), .syncSent(syncSent), .bytesSent(bytesSent),
    .outCfg(outCfg), .flushRequest(flushRequest), .syncRequest(syncRequest),
    .baudTick(baudTick)
  );

  trace_capture_model u_trace_capture_model (
    .ref_clk(ref_clk), .rstn(rstn), .flushRequest(flushRequest),
    .syncRequest(syncRequest), .rate(rate), .flushDrained(flushDrained),
    .syncSent(syncSent), .bytesSent(bytesSent), .flushCount(flushCount)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
    int k;
    k = 0;
    address <= ofs;
    writedata <= wd;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (waitrequest !== 1'b0) begin
      n_errors++;
      conclude();
    end
    rdData = readdata;
    rdResp = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] ofs, input logic [31:0] wd);
    bus(1'b1, ofs, wd);
  endtask

  task automatic rd(input string what, input logic [11:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    chk(what, rdData, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd("supported", SUPPORTED_PORT_WIDTHS_OFS, 32'h0000_000b);
    wr(SUPPORTED_PORT_WIDTHS_OFS, 32'h0);
    rd("supported ro", SUPPORTED_PORT_WIDTHS_OFS, 32'h0000_000b);
    rd("width", CURRENT_PORT_WIDTH_OFS, 32'h1);
    rd("protocol", PIN_PROTOCOL_SELECT_OFS, 32'h1);
    rd("divider", ASYNC_BAUD_DIVIDER_OFS, 32'h0);
    rd("status", FORMATTER_FLUSH_STATUS_OFS, 32'h8);
    rd("control", FORMATTER_FLUSH_CONTROL_OFS, 32'h102);
    rd("sync", SYNC_PERIOD_CONTROL_OFS, 32'h0);
    rd("trigger", TRIGGER_INPUT_STATE_OFS, 32'h0);
    wr(12'h800, 32'hffff_ffff);
    chk("unmapped wr resp", 32'(rdResp), 32'h1);
    rd("unmapped", 12'h800, 32'h0);
    chk("unmapped rd resp", 32'(rdResp), 32'h1);
    $display("done reset");
  endtask

  task automatic t_width();
    for (int i = 0; i < 5; i++) begin
      wr(CURRENT_PORT_WIDTH_OFS, {28'h0, widthVal[i]});
      repeat (2) @(posedge ref_clk);
      chk("width code", 32'(outCfg.portWidthCode), 32'(widthCode[i]));
    end
    wr(CURRENT_PORT_WIDTH_OFS, 32'h8);
    rd("width 4", CURRENT_PORT_WIDTH_OFS, 32'h8);
    wr(CURRENT_PORT_WIDTH_OFS, 32'h1);
    $display("done width");
  endtask

  task automatic t_proto();
    for (int p = 0; p < 3; p++) begin
      wr(PIN_PROTOCOL_SELECT_OFS, 32'(p));
      rd("protocol", PIN_PROTOCOL_SELECT_OFS, 32'(p));
      chk("protocol out", 32'(outCfg.protocol), 32'(p));
    end
    wr(FORMATTER_FLUSH_CONTROL_OFS, 32'hffff_ffbd);
    rd("fmt off", FORMATTER_FLUSH_CONTROL_OFS, 32'h100);
    chk("fmt on out", 32'(outCfg.formatterOn), 32'h0);
    chk("bypass", 32'(outCfg.bypassSecond), 32'h1);
    wr(PIN_PROTOCOL_SELECT_OFS, 32'h0);
    rd("fmt forced", FORMATTER_FLUSH_CONTROL_OFS, 32'h102);
    chk("fmt forced out", 32'(outCfg.formatterOn), 32'h1);
    chk("no bypass", 32'(outCfg.bypassSecond), 32'h0);
    wr(PIN_PROTOCOL_SELECT_OFS, 32'h1);
    rd("fmt restored", FORMATTER_FLUSH_CONTROL_OFS, 32'h100);
    chk("bypass again", 32'(outCfg.bypassSecond), 32'h1);
    wr(PIN_PROTOCOL_SELECT_OFS, 32'hffff_fffe);
    rd("protocol rsvd", PIN_PROTOCOL_SELECT_OFS, 32'h2);
    wr(FORMATTER_FLUSH_CONTROL_OFS, 32'h2);
    wr(PIN_PROTOCOL_SELECT_OFS, 32'h1);
    $display("done protocol");
  endtask

  task automatic t_baud();
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(ASYNC_BAUD_DIVIDER_OFS, 32'hffff_e000 | 32'(6 >> i));
      rd("divider", ASYNC_BAUD_DIVIDER_OFS, 32'(6 >> i));
      n = 0;
      repeat (84) begin
        @(posedge ref_clk);
        n += int'(baudTick);
      end
      chk("baud ticks", 32'(n), 32'(84 / ((6 >> i) + 1)));
    end
    $display("done baud");
  endtask

  task automatic t_flush();
    int k;
    wr(FORMATTER_FLUSH_CONTROL_OFS, 32'h42);
    rd("pending", FORMATTER_FLUSH_STATUS_OFS, 32'h9);
    rd("flush bit", FORMATTER_FLUSH_CONTROL_OFS, 32'h142);
    chk("flush reqs", 32'(flushCount), 32'h1);
    k = 0;
    do begin
      bus(1'b0, FORMATTER_FLUSH_STATUS_OFS, 32'h0);
      k++;
    end while (rdData[0] !== 1'b0 && k < 30);
    chk("drained", rdData, 32'h8);
    if (rdData[0] !== 1'b0) conclude();
    rd("flush clear", FORMATTER_FLUSH_CONTROL_OFS, 32'h102);
    $display("done flush");
  endtask

  // count sync request rises over a window at a given byte rate
  task automatic t_sync(input logic [31:0] cnt, input logic [7:0] r, input int cyc,
                        input int lo, input int hi);
    int   n;
    logic prev;
    wr(SYNC_PERIOD_CONTROL_OFS, cnt);
    rate <= r;
    n = 0;
    prev = syncRequest;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (syncRequest === 1'b1 && prev !== 1'b1) n++;
      prev = syncRequest;
    end
    chk("sync rises", 32'((n >= lo) && (n <= hi)), 32'h1);
  endtask

  task automatic t_trig();
    triggerPin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd("trig high", TRIGGER_INPUT_STATE_OFS, 32'h1);
    triggerPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd("trig low", TRIGGER_INPUT_STATE_OFS, 32'h0);
    $display("done trigger");
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_width();
    t_proto();
    t_baud();
    t_flush();
    t_sync(32'hffff_ffe7, 8'h01, 1300, 9, 10);
    rd("sync rsvd", SYNC_PERIOD_CONTROL_OFS, 32'h7);
    t_sync(32'h6, 8'h01, 600, 0, 0);
    t_sync(32'h10, 8'h80, 2100, 3, 4);
    t_sync(32'h1f, 8'h80, 2100, 3, 4);
    $display("done sync");
    t_trig();
    conclude();
  end
endmodule
